// ---- verilog/output_voltage_setpoint_config.v ----
`include "setpoint_regs.vh"

module output_voltage_setpoint_config #(
    parameter [15:0] TRIM_FACTORY = `RST_TRIM_OFFSET
) (
    input wire clk,
    input wire rst_n,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire [7:0] rd_code,
    input wire margin_high_sel,
    input wire margin_low_sel,
    input wire output_on,
    input wire strap_select_pin,
    input wire [15:0] voltage_strap_pin_code,
    input wire [15:0] sensed_output,
    input wire reject_clear,
    output reg [15:0] rd_data_reg,
    output reg [15:0] commanded_voltage_reg,
    output reg [15:0] loop_reference_reg,
    output reg [15:0] scaled_sense_reg,
    output reg [15:0] active_scale_reg,
    output reg write_rejected_reg,
    output reg reject_flag_reg
);

    localparam integer TICK_SPAN = `SLEW_TICK_CYCLES - 1;
    localparam [6:0] TICK_LAST = TICK_SPAN[6:0];

    reg [15:0] base_setpoint_reg;
    reg [15:0] output_trim_offset_reg;
    reg [15:0] output_ceiling_limit_reg;
    reg [15:0] margin_upper_target_reg;
    reg [15:0] margin_lower_target_reg;
    reg [15:0] setpoint_slew_rate_reg;
    reg [15:0] loop_scale_factor_reg;

    reg strap_meta_reg;
    reg strap_sync_reg;
    reg [15:0] strap_code_meta_reg;
    reg [15:0] strap_code_sync_reg;

    reg [6:0] tick_count_reg;
    reg step_tick_reg;

    reg [15:0] target_reg;
    reg [15:0] target_next;
    reg [15:0] rd_data_next;
    reg accept;
    reg reject;

    wire [15:0] slewed_level;
    wire [15:0] effective_scale;
    wire [1:0] scale_shift_now;
    wire signed [19:0] trim_units_now;

    // Linear-11 check for the loop scale factor
    function scale_is_valid;
        input [15:0] code;
        begin
            scale_is_valid = (code == `SCALE_1_000) || (code == `SCALE_0_500) ||
                (code == `SCALE_0_250) || (code == `SCALE_0_125);
        end
    endfunction

    // Right shift equal to dividing by the factor's inverse
    function [1:0] scale_shift;
        input [15:0] code;
        begin
            case (code)
                `SCALE_0_500: scale_shift = 2'h1;
                `SCALE_0_250: scale_shift = 2'h2;
                `SCALE_0_125: scale_shift = 2'h3;
                default: scale_shift = 2'h0;
            endcase
        end
    endfunction

    // Trim word converted to output-voltage codes
    function signed [19:0] trim_units;
        input [15:0] trim;
        input [1:0] shift;
        reg signed [19:0] wide;
        begin
            wide = {{4{trim[15]}}, trim};
            trim_units = wide <<< shift;
        end
    endfunction

    function vout_in_range;
        input [15:0] code;
        begin
            vout_in_range = (code >= `VOUT_CODE_MIN) && (code <= `VOUT_CODE_MAX);
        end
    endfunction

    assign effective_scale = strap_sync_reg ?
        ((strap_code_sync_reg < `STRAP_BAND_1V8) ? `SCALE_1_000 :
         (strap_code_sync_reg < `STRAP_BAND_3V3) ? `SCALE_0_500 :
         (strap_code_sync_reg <= `STRAP_BAND_5V0) ? `SCALE_0_250 :
         `SCALE_0_125) :
        loop_scale_factor_reg;
    assign scale_shift_now = scale_shift(effective_scale);
    assign trim_units_now = trim_units(output_trim_offset_reg, scale_shift_now);

    // Strap level and code are static after power-up, so a plain two-stage
    // sample of the code bus is enough; it is not a safe crossing for a moving bus
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
            strap_code_meta_reg <= 16'h0000;
            strap_code_sync_reg <= 16'h0000;
        end
        else
        begin
            strap_meta_reg <= strap_select_pin;
            strap_sync_reg <= strap_meta_reg;
            strap_code_meta_reg <= voltage_strap_pin_code;
            strap_code_sync_reg <= strap_code_meta_reg;
        end
    end

    // Write checking
    always @*
    begin : write_check
        reg signed [19:0] wr_units;
        reg [19:0] wr_mag;
        wr_units = trim_units(cmd_wdata, scale_shift_now);
        wr_mag = wr_units[19] ? (20'h00000 - wr_units) : wr_units;
        accept = 1'b0;
        reject = 1'b0;
        if (cmd_write)
        begin
            case (cmd_code)
                `CMD_BASE_SETPOINT, `CMD_CEILING_LIMIT,
                `CMD_MARGIN_UPPER, `CMD_MARGIN_LOWER:
                begin
                    accept = vout_in_range(cmd_wdata);
                    reject = !accept;
                end
                `CMD_TRIM_OFFSET:
                begin
                    accept = (wr_mag <= `TRIM_UNITS_LIMIT);
                    reject = !accept;
                end
                `CMD_SLEW_RATE:
                begin
                    accept = (cmd_wdata[`EXP_MSB:`EXP_LSB] == `SLEW_EXPONENT) &&
                        (cmd_wdata[`MAN_MSB:`MAN_LSB] >= `SLEW_MAN_MIN) &&
                        (cmd_wdata[`MAN_MSB:`MAN_LSB] <= `SLEW_MAN_MAX);
                    reject = !accept;
                end
                `CMD_LOOP_SCALE:
                begin
                    accept = scale_is_valid(cmd_wdata);
                    reject = !accept;
                end
                `CMD_FORMAT_MODE:
                begin
                    reject = 1'b1;
                end
                default:
                begin
                    accept = 1'b0;
                    reject = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            base_setpoint_reg <= `RST_BASE_SETPOINT;
            output_trim_offset_reg <= TRIM_FACTORY;
            output_ceiling_limit_reg <= `RST_CEILING_LIMIT;
            margin_upper_target_reg <= `RST_MARGIN_UPPER;
            margin_lower_target_reg <= `RST_MARGIN_LOWER;
            setpoint_slew_rate_reg <= `RST_SLEW_RATE;
            loop_scale_factor_reg <= `RST_LOOP_SCALE;
        end
        else if (accept)
        begin
            case (cmd_code)
                `CMD_BASE_SETPOINT: base_setpoint_reg <= cmd_wdata;
                `CMD_TRIM_OFFSET: output_trim_offset_reg <= cmd_wdata;
                `CMD_CEILING_LIMIT: output_ceiling_limit_reg <= cmd_wdata;
                `CMD_MARGIN_UPPER: margin_upper_target_reg <= cmd_wdata;
                `CMD_MARGIN_LOWER: margin_lower_target_reg <= cmd_wdata;
                `CMD_SLEW_RATE: setpoint_slew_rate_reg <= cmd_wdata;
                `CMD_LOOP_SCALE: loop_scale_factor_reg <= cmd_wdata;
                default: base_setpoint_reg <= base_setpoint_reg;
            endcase
        end
    end

    // A new rejection in the clearing cycle keeps the flag set
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            write_rejected_reg <= 1'b0;
            reject_flag_reg <= 1'b0;
        end
        else
        begin
            write_rejected_reg <= reject;
            if (reject)
                reject_flag_reg <= 1'b1;
            else if (reject_clear)
                reject_flag_reg <= 1'b0;
        end
    end

    // Effective target before slewing
    always @*
    begin : target_calc
        reg [15:0] selected;
        reg signed [19:0] sum;
        selected = base_setpoint_reg;
        if (margin_high_sel)
            selected = margin_upper_target_reg;
        else if (margin_low_sel)
            selected = margin_lower_target_reg;
        sum = $signed({4'h0, selected}) + trim_units_now;
        if (sum[19])
            target_next = 16'h0000;
        else if (sum > $signed({4'h0, output_ceiling_limit_reg}))
            target_next = output_ceiling_limit_reg;
        else
            target_next = sum[15:0];
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            tick_count_reg <= 7'h00;
            step_tick_reg <= 1'b0;
            target_reg <= `RST_BASE_SETPOINT;
        end
        else
        begin
            target_reg <= target_next;
            if (tick_count_reg == TICK_LAST)
            begin
                tick_count_reg <= 7'h00;
                step_tick_reg <= 1'b1;
            end
            else
            begin
                tick_count_reg <= tick_count_reg + 7'h01;
                step_tick_reg <= 1'b0;
            end
        end
    end

    // While off, the turn-on and turn-off ramps are owned elsewhere
    slew_limiter slew (
        .clk(clk),
        .rst_n(rst_n),
        .step_tick(step_tick_reg),
        .rate_mantissa(setpoint_slew_rate_reg[5:0]),
        .follow_now(!output_on),
        .target(target_reg),
        .level_reg(slewed_level)
    );

    // A lowered ceiling takes effect at once rather than slewing down
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            commanded_voltage_reg <= `RST_BASE_SETPOINT;
            loop_reference_reg <= `RST_BASE_SETPOINT;
            scaled_sense_reg <= 16'h0000;
            active_scale_reg <= `RST_LOOP_SCALE;
        end
        else
        begin
            if (slewed_level > output_ceiling_limit_reg)
            begin
                commanded_voltage_reg <= output_ceiling_limit_reg;
                loop_reference_reg <= output_ceiling_limit_reg >> scale_shift_now;
            end
            else
            begin
                commanded_voltage_reg <= slewed_level;
                loop_reference_reg <= slewed_level >> scale_shift_now;
            end
            scaled_sense_reg <= sensed_output >> scale_shift_now;
            active_scale_reg <= effective_scale;
        end
    end

    always @*
    begin
        case (rd_code)
            `CMD_FORMAT_MODE: rd_data_next = `FORMAT_MODE_VALUE;
            `CMD_BASE_SETPOINT: rd_data_next = base_setpoint_reg;
            `CMD_TRIM_OFFSET: rd_data_next = output_trim_offset_reg;
            `CMD_CEILING_LIMIT: rd_data_next = output_ceiling_limit_reg;
            `CMD_MARGIN_UPPER: rd_data_next = margin_upper_target_reg;
            `CMD_MARGIN_LOWER: rd_data_next = margin_lower_target_reg;
            `CMD_SLEW_RATE: rd_data_next = setpoint_slew_rate_reg;
            `CMD_LOOP_SCALE: rd_data_next = effective_scale;
            default: rd_data_next = 16'h0000;
        endcase
    end

    always @(posedge clk)
    begin
        if (!rst_n)
            rd_data_reg <= 16'h0000;
        else
            rd_data_reg <= rd_data_next;
    end

endmodule

// ---- shared/setpoint_regs.vh ----
`ifndef SETPOINT_REGS_VH
`define SETPOINT_REGS_VH

// Command codes, which are also the register offsets
`define CMD_FORMAT_MODE 8'h20
`define CMD_BASE_SETPOINT 8'h21
`define CMD_TRIM_OFFSET 8'h22
`define CMD_CEILING_LIMIT 8'h24
`define CMD_MARGIN_UPPER 8'h25
`define CMD_MARGIN_LOWER 8'h26
`define CMD_SLEW_RATE 8'h27
`define CMD_LOOP_SCALE 8'h29

// Reset values
`define RST_BASE_SETPOINT 16'h0133
`define RST_CEILING_LIMIT 16'h1c00
`define RST_MARGIN_UPPER 16'h0142
`define RST_MARGIN_LOWER 16'h0123
`define RST_SLEW_RATE 16'he002
`define RST_LOOP_SCALE 16'he808
`define RST_TRIM_OFFSET 16'h0000

// Fixed output format: ULINEAR16 mode with exponent -9
`define FORMAT_MODE_VALUE 16'h0017

// Linear-11 field layout
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define MAN_LSB 0
`define MAN_SIGN_BIT 10

// Fixed exponents
`define SLEW_EXPONENT 5'h1c
`define SCALE_EXPONENT 5'h1d

// Slew mantissa range, 0.0625 to 2 mV/us in 0.0625 steps
`define SLEW_MAN_MIN 11'h001
`define SLEW_MAN_MAX 11'h020

// Permitted loop scale encodings
`define SCALE_1_000 16'he808
`define SCALE_0_500 16'he804
`define SCALE_0_250 16'he802
`define SCALE_0_125 16'he801

// Output voltage code range, 0.3 V to 14 V at 1.953 mV
`define VOUT_CODE_MIN 16'h009a
`define VOUT_CODE_MAX 16'h1c00

// Trim offset limit of 2 V in output-voltage codes
`define TRIM_UNITS_LIMIT 20'h00400

// Strap bands: below 1.8 V, below 3.3 V, up to 5.0 V
`define STRAP_BAND_1V8 16'h039a
`define STRAP_BAND_3V3 16'h069a
`define STRAP_BAND_5V0 16'h0a00

// Slew stepping: one tick every 500 ns, rate units of 1/64 mV
`define CLK_PERIOD_NS 5
`define SLEW_TICK_NS 500
`define SLEW_TICK_CYCLES (`SLEW_TICK_NS / `CLK_PERIOD_NS)
`define SLEW_LSB_UNITS 8'h7d

`endif

// ---- verilog/slew_limiter.v ----
`include "setpoint_regs.vh"

module slew_limiter (
    input wire clk,
    input wire rst_n,
    input wire step_tick,
    input wire [5:0] rate_mantissa,
    input wire follow_now,
    input wire [15:0] target,
    output reg [15:0] level_reg
);

    reg [7:0] acc_reg;
    reg [7:0] acc_next;
    reg [15:0] level_next;
    reg [7:0] acc_sum;

    // Each tick adds twice the mantissa in 1/64 mV; one code is 125 units
    always @*
    begin
        acc_sum = acc_reg + {1'b0, rate_mantissa, 1'b0};
        acc_next = acc_reg;
        level_next = level_reg;
        if (follow_now)
        begin
            level_next = target;
            acc_next = 8'h00;
        end
        else if (level_reg == target)
        begin
            acc_next = 8'h00;
        end
        else if (step_tick)
        begin
            if (acc_sum >= `SLEW_LSB_UNITS)
            begin
                acc_next = acc_sum - `SLEW_LSB_UNITS;
                if (level_reg < target)
                    level_next = level_reg + 16'h0001;
                else
                    level_next = level_reg - 16'h0001;
            end
            else
            begin
                acc_next = acc_sum;
            end
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_reg <= 8'h00;
            level_reg <= `RST_BASE_SETPOINT;
        end
        else
        begin
            acc_reg <= acc_next;
            level_reg <= level_next;
        end
    end

endmodule

// ---- dv/setpoint_props.sv ----
module setpoint_props (
    input wire clk,
    input wire rst_n,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire [7:0] rd_code,
    input wire [15:0] sensed_output,
    input wire reject_clear,
    input wire [15:0] rd_data_reg,
    input wire [15:0] commanded_voltage_reg,
    input wire [15:0] scaled_sense_reg,
    input wire [15:0] active_scale_reg,
    input wire write_rejected_reg,
    input wire reject_flag_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence slew_write;
        cmd_write && cmd_code == 8'h27;
    endsequence
    sequence scale_bad;
        cmd_write && cmd_code == 8'h29
            && !(cmd_wdata inside {16'he808, 16'he804, 16'he802, 16'he801});
    endsequence
    // Four cycles leave room for one register stage on the sense path
    sequence sense_held;
        ($stable(sensed_output) && active_scale_reg == 16'he808) [*4];
    endsequence

    format_ro_a: assert property (cmd_write && cmd_code == 8'h20 |=> write_rejected_reg)
        else $error("format write not refused");
    format_read_a: assert property (rd_code == 8'h20 |=> rd_data_reg == 16'h0017)
        else $error("format read wrong");
    slew_exp_a: assert property (slew_write ##0 cmd_wdata[15:11] != 5'h1c |=> write_rejected_reg && reject_flag_reg)
        else $error("slew exponent not refused");
    slew_range_a: assert property (slew_write ##0 cmd_wdata[15:11] == 5'h1c
        && (cmd_wdata[10:0] == 11'h000 || cmd_wdata[10:0] > 11'h020) |=> write_rejected_reg)
        else $error("slew range not refused");
    slew_accept_a: assert property (slew_write ##0 cmd_wdata[15:11] == 5'h1c
        && cmd_wdata[10:0] != 11'h000 && cmd_wdata[10:0] <= 11'h020 |=> !write_rejected_reg)
        else $error("legal slew refused");
    scale_code_a: assert property (scale_bad |=> write_rejected_reg && reject_flag_reg)
        else $error("scale code not refused");
    scale_legal_a: assert property (active_scale_reg inside {16'he808, 16'he804, 16'he802, 16'he801})
        else $error("illegal active scale");
    ceiling_top_a: assert property (commanded_voltage_reg <= 16'h1c00)
        else $error("commanded above ceiling");
    flag_hold_a: assert property (reject_flag_reg && !reject_clear |=> reject_flag_reg)
        else $error("reject flag lost");
    flag_clear_a: assert property (reject_clear && !cmd_write |=> !reject_flag_reg)
        else $error("reject flag not cleared");
    sense_scale_a: assert property (sense_held |-> scaled_sense_reg == sensed_output)
        else $error("unity sense scaling wrong");
endmodule

// ---- dv/pmbus_host_model.sv ----
module pmbus_host_model #(
    parameter logic [15:0] TRIM_FACTORY = 16'h0000
) (
    input wire clk,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    output logic [7:0] rd_code
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        rd_code = 8'h00;
    end
    task automatic write_word(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk);
        cmd_write = 1'b1;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge clk);
        cmd_write = 1'b0;
        // Scrambled after release so a stale word never passes for a fresh one
        cmd_wdata = ~data;
    endtask
    task automatic read_word(input logic [7:0] code);
        @(negedge clk);
        rd_code = code;
        @(negedge clk);
    endtask
    task automatic write_trim(input logic [15:0] offset);
        write_word(8'h22, offset + TRIM_FACTORY);
    endtask
    task automatic set_output(input logic [15:0] v);
        logic [15:0] f;
        f = v < 16'h039a ? 16'he808 : v < 16'h069a ? 16'he804 : v <= 16'h0a00 ? 16'he802 : 16'he801;
        write_word(8'h29, f);
        write_word(8'h21, v);
    endtask
endmodule

// ---- dv/output_voltage_setpoint_config_test.sv ----
bind output_voltage_setpoint_config setpoint_props chk (.clk(clk), .rst_n(rst_n),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_code(rd_code),
    .sensed_output(sensed_output), .reject_clear(reject_clear), .rd_data_reg(rd_data_reg),
    .commanded_voltage_reg(commanded_voltage_reg), .scaled_sense_reg(scaled_sense_reg),
    .active_scale_reg(active_scale_reg), .write_rejected_reg(write_rejected_reg),
    .reject_flag_reg(reject_flag_reg));

module output_voltage_setpoint_config_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int sel; logic [15:0] val;} note_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic margin_high_sel = 1'b0, margin_low_sel = 1'b0, output_on = 1'b0, reject_clear = 1'b0;
    logic strap_select_pin = 1'b0;
    logic [15:0] voltage_strap_pin_code = 16'h0100, sensed_output = 16'h0000;
    wire cmd_write, write_rejected_reg, reject_flag_reg;
    wire [7:0] cmd_code, rd_code;
    wire [15:0] cmd_wdata, rd_data_reg, commanded_voltage_reg, loop_reference_reg;
    wire [15:0] scaled_sense_reg, active_scale_reg;
    int mismatches = 0;
    int comparisons = 0;
    int i;
    logic [10:0] m;
    note_t notes[$];
    note_t cur;
    event sample_now;
    logic [7:0] rst_code [8] = '{8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29};
    logic [15:0] rst_val [8] = '{16'h0017, 16'h0133, 16'h0000, 16'h1c00, 16'h0142, 16'h0123,
        16'he002, 16'he808};
    logic [7:0] bad_code [9] = '{8'h27, 8'h27, 8'h27, 8'h29, 8'h29, 8'h20, 8'h24, 8'h25, 8'h22};
    logic [15:0] bad_data [9] = '{16'he000, 16'he021, 16'he820, 16'he803, 16'h0808, 16'h0017,
        16'h0099, 16'h1c01, 16'h0401};
    logic [15:0] bad_keep [9] = '{16'he002, 16'he002, 16'he002, 16'he808, 16'he808, 16'h0017,
        16'h1c00, 16'h0142, 16'h0000};
    logic [15:0] scale_code [4] = '{16'he804, 16'he802, 16'he801, 16'he808};
    logic [15:0] strap_code [4] = '{16'h0399, 16'h039a, 16'h0a00, 16'h0a01};
    logic [15:0] strap_exp [4] = '{16'he808, 16'he804, 16'he802, 16'he801};

    always #2.5 clk = ~clk;

    output_voltage_setpoint_config DUT (.clk(clk), .rst_n(rst_n), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_code(rd_code),
        .margin_high_sel(margin_high_sel), .margin_low_sel(margin_low_sel), .output_on(output_on),
        .strap_select_pin(strap_select_pin), .voltage_strap_pin_code(voltage_strap_pin_code),
        .sensed_output(sensed_output), .reject_clear(reject_clear), .rd_data_reg(rd_data_reg),
        .commanded_voltage_reg(commanded_voltage_reg), .loop_reference_reg(loop_reference_reg),
        .scaled_sense_reg(scaled_sense_reg), .active_scale_reg(active_scale_reg),
        .write_rejected_reg(write_rejected_reg), .reject_flag_reg(reject_flag_reg));
    pmbus_host_model host (.clk(clk), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rd_code(rd_code));

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic note_exp(input int sel, input logic [15:0] val);
        notes.push_back('{sel, val});
        -> sample_now;
    endtask
    task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic rej);
        host.write_word(code, data);
        note_exp(1, {15'h0000, rej});
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        host.read_word(code);
        note_exp(0, exp);
    endtask
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Notes are drained as a batch since several may land in one time step
    always @(sample_now)
    begin
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            case (cur.sel)
                0: check16("read data", cur.val, rd_data_reg);
                1: check1("reject pulse", cur.val[0], write_rejected_reg);
                2: check1("reject flag", cur.val[0], reject_flag_reg);
                3: check16("commanded", cur.val, commanded_voltage_reg);
                4: check16("loop reference", cur.val, loop_reference_reg);
                5: check16("active scale", cur.val, active_scale_reg);
                7: check16("scaled sense", cur.val, scaled_sense_reg);
                default: check1("slew pending", 1'b1, commanded_voltage_reg < cur.val);
            endcase
        end
    end

    initial
    begin
        #100000;
        mismatches++;
        end_sim();
    end

    initial
    begin
        void'($urandom(32'h45eb));
        sensed_output = 16'($urandom);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 8; i++)
            rd(rst_code[i], rst_val[i]);
        for (i = 0; i < 9; i++)
        begin
            wr(bad_code[i], bad_data[i], 1'b1);
            rd(bad_code[i], bad_keep[i]);
        end
        note_exp(2, 16'h0001);
        reject_clear = 1'b1;
        @(negedge clk);
        reject_clear = 1'b0;
        note_exp(2, 16'h0000);
        for (i = 0; i < 6; i++)
        begin
            m = i == 0 ? 11'h001 : i == 1 ? 11'h020 : 11'($urandom_range(32, 1));
            wr(8'h27, {5'h1c, m}, 1'b0);
            rd(8'h27, {5'h1c, m});
        end
        for (i = 0; i < 4; i++)
        begin
            wr(8'h29, scale_code[i], 1'b0);
            // Active scale is registered one cycle behind the stored factor
            @(negedge clk);
            note_exp(5, scale_code[i]);
        end
        wr(8'h21, 16'h0200, 1'b0);
        host.write_trim(16'h0010);
        settle();
        note_exp(3, 16'h0210);
        note_exp(4, 16'h0210);
        wr(8'h24, 16'h0150, 1'b0);
        settle();
        note_exp(3, 16'h0150);
        wr(8'h24, 16'h1c00, 1'b0);
        margin_high_sel = 1'b1;
        margin_low_sel = 1'b1;
        settle();
        note_exp(3, 16'h0152);
        margin_high_sel = 1'b0;
        settle();
        note_exp(3, 16'h0133);
        margin_low_sel = 1'b0;
        host.set_output(16'h0400);
        settle();
        note_exp(3, 16'h0420);
        note_exp(4, 16'h0210);
        wr(8'h27, 16'he020, 1'b0);
        output_on = 1'b1;
        wr(8'h21, 16'h0404, 1'b0);
        repeat (20) @(negedge clk);
        note_exp(6, 16'h0424);
        repeat (1500) @(negedge clk);
        note_exp(3, 16'h0424);
        output_on = 1'b0;
        wr(8'h21, 16'h0200, 1'b0);
        settle();
        note_exp(3, 16'h0220);
        strap_select_pin = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            voltage_strap_pin_code = strap_code[i];
            settle();
            note_exp(5, strap_exp[i]);
            note_exp(7, sensed_output >> i);
        end
        end_sim();
    end
endmodule
